// ==== bdp_top.sv ====
// bridge decimation path: two sigma-delta decimators, a pressure sample
// fifo, byte-wide sample registers and the front-end configuration.
// assumes modulator symbols synchronous to i_clk_sys and sampled on an
// internal 1 MHz enable; software uses the one-cycle register port.
//
// The plain strobed port and the address map were chosen for this implementation.
`include "bdp_params.svh"

// Summary of operation
// - accept 3-bit modulator symbols at 1 MHz
// - pressure sample every 128 us
// - pressure sample is 16-bit signed
// - full scale maps linearly onto code range
// - pressure sample readable as high/low bytes
// - two independent channels, each own converter
// - five-bit pressure gain code
// - two-bit temperature gain, four settings
// - two-bit bridge excitation select
// - three-bit temperature current source magnitude
// - junction sensor selectable as temperature input
// - discard results during 50 us reference settling
// - temperature channel also 16-bit signed, 128 us
module bdp_top #(
    parameter int FIFO_DEPTH = 32,
    parameter int SETTLE_CYC = `BDP_SETTLE_CYC
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // modulator streams
    input wire logic [2:0] i_p_sym,
    input wire logic [2:0] i_t_sym,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // front-end configuration and state
    output bdp_pkg::bdp_cfg_type o_cfg,
    output logic o_ref_settled,
    output logic o_mod_en
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam int DW = $clog2(`BDP_MOD_DIV);
    localparam int SW = $clog2(SETTLE_CYC + 1);

    if ((SETTLE_CYC < 1) || (FIFO_DEPTH > 128)) begin : g_bad_top
        $error("bdp_top needs a settle count of at least one and depth up to 128");
    end

    // ------------------------------------------------------------
    // modulator rate enable
    // ------------------------------------------------------------
    logic [DW-1:0] div_reg, div_next;       // core cycles into this symbol
    logic mod_en_next;

    // one pulse per modulator period; symbols are taken on it
    always_comb begin
        mod_en_next = (div_reg == DW'(`BDP_MOD_DIV - 1));
        div_next = mod_en_next ? '0 : div_reg + 1'b1;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            div_reg <= '0;
            o_mod_en <= 1'b0;
        end else begin
            div_reg <= div_next;
            o_mod_en <= mod_en_next;
        end
    end

    // ------------------------------------------------------------
    // the two conversion channels
    // ------------------------------------------------------------
    bdp_pkg::bdp_smp_type p_smp;            // pressure decimator output
    bdp_pkg::bdp_smp_type t_smp;            // temperature decimator output

    // separate filters so the channels never share state
    bdp_decim #(.IN_W(3), .OUT_W(16), .RATIO(`BDP_DEC_RATIO)) u_p_decim (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_sym_en(o_mod_en),
        .i_sym(i_p_sym),
        .o_smp(p_smp)
    );

    bdp_decim #(.IN_W(3), .OUT_W(16), .RATIO(`BDP_DEC_RATIO)) u_t_decim (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_sym_en(o_mod_en),
        .i_sym(i_t_sym),
        .o_smp(t_smp)
    );

    // ------------------------------------------------------------
    // reference settling after power-up
    // ------------------------------------------------------------
    bdp_pkg::bdp_ref_type ref_reg, ref_next;
    logic [SW-1:0] set_reg, set_next;       // cycles since reset release, held at SETTLE_CYC once settled

    // results before the reference settles are thrown away; the first filter
    // output comes after settling, so its start-up transient is not hidden
    always_comb begin
        ref_next = ref_reg;
        set_next = set_reg;
        unique case (ref_reg)
            bdp_pkg::BDP_SETTLING: begin
                set_next = set_reg + 1'b1;
                if (set_reg == SW'(SETTLE_CYC - 1)) begin
                    ref_next = bdp_pkg::BDP_RUNNING;
                end
            end
            bdp_pkg::BDP_RUNNING: begin
                set_next = set_reg;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ref_reg <= bdp_pkg::BDP_SETTLING;
            set_reg <= '0;
        end else begin
            ref_reg <= ref_next;
            set_reg <= set_next;
        end
    end

    assign o_ref_settled = (ref_reg == bdp_pkg::BDP_RUNNING);

    // ------------------------------------------------------------
    // pressure fifo and the sample holding register
    // ------------------------------------------------------------
    logic push;                             // settled pressure sample
    logic s_ready;                          // fifo can take it
    logic m_valid;
    logic m_ready;
    logic [15:0] m_data;
    logic [LW-1:0] level;
    logic consume;                          // low byte read ends a sample
    logic [15:0] hold_reg, hold_next;       // sample shown to software
    logic full_reg, full_next;              // hold_reg holds an unread sample
    logic ovf_reg, ovf_next;                // sample lost to a full fifo
    logic ovf_clr;

    assign push = p_smp.vld && o_ref_settled;
    assign consume = i_rd && (i_addr == `BDP_OFS_P_LOW) && full_reg;
    // the fifo drains only when the holding register is free, so an
    // unread sample stalls it and the fifo really fills
    assign m_ready = !full_reg || consume;

    bdp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_s_valid(push),
        .i_s_data(p_smp.data),
        .o_s_ready(s_ready),
        .o_m_valid(m_valid),
        .o_m_data(m_data),
        .i_m_ready(m_ready),
        .o_level(level)
    );

    // both bytes load together, and only once the low byte of the
    // previous sample was read, so a high/low pair never splits
    always_comb begin
        hold_next = hold_reg;
        full_next = full_reg && !consume;
        if (m_valid && m_ready) begin
            hold_next = m_data;
            full_next = 1'b1;
        end
        // the modulator cannot be paused, so a full fifo drops the
        // sample; the flag records it and a set beats a clear
        ovf_next = ovf_reg && !ovf_clr;
        if (push && !s_ready) begin
            ovf_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_reg <= '0;
            full_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            full_reg <= full_next;
            ovf_reg <= ovf_next;
        end
    end

    // ------------------------------------------------------------
    // temperature sample and configuration registers
    // ------------------------------------------------------------
    logic [15:0] temp_reg, temp_next;       // latest settled temperature
    bdp_pkg::bdp_cfg_type cfg_reg, cfg_next;

    // one write strobe, decoded per offset
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = i_wr && (i_addr == ofs);
    endfunction : wr_hit

    always_comb begin
        temp_next = temp_reg;
        cfg_next = cfg_reg;
        // the whole word updates at once, but a high/low read pair can straddle an update
        if (t_smp.vld && o_ref_settled) begin
            temp_next = t_smp.data;
        end
        if (wr_hit(`BDP_OFS_P_GAIN)) begin
            cfg_next.p_gain = i_wdata[4:0];
        end
        if (wr_hit(`BDP_OFS_T_GAIN)) begin
            cfg_next.t_gain = i_wdata[1:0];
        end
        if (wr_hit(`BDP_OFS_BRIDGE)) begin
            // code 3 is kept as written; the supply treats it as 1.25 V
            cfg_next.bridge_excitation_select = i_wdata[1:0];
        end
        if (wr_hit(`BDP_OFS_TEMP)) begin
            cfg_next.temp_current_select = i_wdata[2:0];
            cfg_next.t_int_src = i_wdata[`BDP_TEMP_INT_BIT];
        end
    end

    // spelled out: a continuous assign would not follow the function's hidden reads
    assign ovf_clr = i_wr && (i_addr == `BDP_OFS_STATUS) && i_wdata[`BDP_ST_OVF_BIT];

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            temp_reg <= '0;
            cfg_reg <= '{p_gain: `BDP_RST_P_GAIN, t_gain: `BDP_RST_T_GAIN,
                         bridge_excitation_select: `BDP_RST_BRIDGE,
                         temp_current_select: `BDP_RST_T_CUR,
                         t_int_src: `BDP_RST_T_INT};
        end else begin
            temp_reg <= temp_next;
            cfg_reg <= cfg_next;
        end
    end

    assign o_cfg = cfg_reg;

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic [7:0] rdata_next;
    logic [7:0] status;

    always_comb begin
        status = '0;
        status[`BDP_ST_VALID_BIT] = full_reg;
        status[`BDP_ST_OVF_BIT] = ovf_reg;
        status[`BDP_ST_SETTLED_BIT] = o_ref_settled;
        rdata_next = '0;
        if (i_rd) begin
            unique case (i_addr)
                `BDP_OFS_P_HIGH: rdata_next = hold_reg[15:8];
                `BDP_OFS_P_LOW: rdata_next = hold_reg[7:0];
                `BDP_OFS_T_HIGH: rdata_next = temp_reg[15:8];
                `BDP_OFS_T_LOW: rdata_next = temp_reg[7:0];
                `BDP_OFS_P_GAIN: rdata_next = {3'h0, cfg_reg.p_gain};
                `BDP_OFS_T_GAIN: rdata_next = {6'h00, cfg_reg.t_gain};
                `BDP_OFS_BRIDGE: rdata_next = {6'h00, cfg_reg.bridge_excitation_select};
                `BDP_OFS_TEMP: rdata_next = {3'h0, cfg_reg.t_int_src, 1'b0,
                                             cfg_reg.temp_current_select};
                `BDP_OFS_STATUS: rdata_next = status;
                `BDP_OFS_LEVEL: rdata_next = 8'(level);
                // unmapped offsets read as zero
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    // helper: cycles since reset, saturating above the settle count
    logic [SW:0] age_reg;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            age_reg <= '0;
        end else if (age_reg <= (SW + 1)'(SETTLE_CYC)) begin
            age_reg <= age_reg + 1'b1;
        end
    end

    mod_spacing_a: assert property (o_mod_en |=> !o_mod_en [*8])
        else $error("modulator enable pulses too close");
    settle_time_a: assert property ($rose(o_ref_settled) |->
        age_reg == (SW + 1)'(SETTLE_CYC))
        else $error("reference settled at the wrong time");
    settle_gate_a: assert property (!o_ref_settled |-> !push && $stable(temp_reg))
        else $error("sample accepted before settling");
    high_byte_a: assert property (i_rd && i_addr == `BDP_OFS_P_HIGH |=>
        o_rdata == $past(hold_reg[15:8]))
        else $error("pressure high byte read wrong");
    pair_hold_a: assert property (full_reg && !consume |=> $stable(hold_reg) && full_reg)
        else $error("sample changed before its low byte was read");
    temp_load_a: assert property (t_smp.vld && o_ref_settled |=>
        temp_reg == $past(t_smp.data))
        else $error("temperature sample not loaded");
    // strobe decode written out, so the antecedent uses sampled values
    p_gain_a: assert property (i_wr && i_addr == `BDP_OFS_P_GAIN |=>
        o_cfg.p_gain == $past(i_wdata[4:0]))
        else $error("pressure gain not written");
    t_gain_a: assert property (i_wr && i_addr == `BDP_OFS_T_GAIN |=>
        o_cfg.t_gain == $past(i_wdata[1:0]))
        else $error("temperature gain not written");
    bridge_sel_a: assert property (i_wr && i_addr == `BDP_OFS_BRIDGE |=>
        o_cfg.bridge_excitation_select == $past(i_wdata[1:0]))
        else $error("bridge excitation not written");
    temp_ctl_a: assert property (i_wr && i_addr == `BDP_OFS_TEMP |=>
        o_cfg.temp_current_select == $past(i_wdata[2:0]) &&
        o_cfg.t_int_src == $past(i_wdata[`BDP_TEMP_INT_BIT]))
        else $error("temperature control not written");
    ovf_set_a: assert property (push && !s_ready |=> ovf_reg)
        else $error("lost sample not flagged");

endmodule : bdp_top

// ==== bdp_params.svh ====
// constants for the bridge decimation path: register offsets, field
// positions, reset values and timing figures.
// assumes a 40 MHz core clock and an 8-bit register port.
`ifndef BDP_PARAMS_SVH
`define BDP_PARAMS_SVH

// core clock and modulator timing, in ns
`define BDP_CLK_PERIOD_NS 25
`define BDP_MOD_PERIOD_NS 1000
`define BDP_OUT_PERIOD_NS 128000
`define BDP_SETTLE_NS 50000
// derived cycle counts (settle is a least time, so it rounds up)
`define BDP_MOD_DIV (`BDP_MOD_PERIOD_NS / `BDP_CLK_PERIOD_NS)
`define BDP_DEC_RATIO (`BDP_OUT_PERIOD_NS / `BDP_MOD_PERIOD_NS)
`define BDP_SETTLE_CYC ((`BDP_SETTLE_NS + `BDP_CLK_PERIOD_NS - 1) / `BDP_CLK_PERIOD_NS)

// register byte offsets
`define BDP_OFS_P_HIGH 8'h00
`define BDP_OFS_P_LOW 8'h01
`define BDP_OFS_T_HIGH 8'h02
`define BDP_OFS_T_LOW 8'h03
`define BDP_OFS_P_GAIN 8'h04
`define BDP_OFS_T_GAIN 8'h05
`define BDP_OFS_BRIDGE 8'h06
`define BDP_OFS_TEMP 8'h07
`define BDP_OFS_STATUS 8'h08
`define BDP_OFS_LEVEL 8'h09

// field positions
`define BDP_TEMP_INT_BIT 4
`define BDP_ST_VALID_BIT 0
`define BDP_ST_OVF_BIT 1
`define BDP_ST_SETTLED_BIT 2

// reset values
`define BDP_RST_P_GAIN 5'h00
`define BDP_RST_T_GAIN 2'h0
`define BDP_RST_BRIDGE 2'h0
`define BDP_RST_T_CUR 3'h0
`define BDP_RST_T_INT 1'b0

`endif

// ==== bdp_pkg.sv ====
// types shared by the bridge decimation path modules.
// assumes bdp_params.svh supplies the numeric constants.
package bdp_pkg;

    // configuration fields steering the analog front end
    typedef struct packed {
        logic [4:0] p_gain;      // pressure gain code, 32 steps
        logic [1:0] t_gain;      // temperature gain, four steps
        logic [1:0] bridge_excitation_select;
        logic [2:0] temp_current_select;
        logic t_int_src;         // junction sensor feeds temperature channel
    } bdp_cfg_type;

    // one decimated sample with its strobe
    typedef struct packed {
        logic vld;
        logic [15:0] data;
    } bdp_smp_type;

    // power-up reference settling
    typedef enum logic [0:0] {
        BDP_SETTLING = 1'b0,
        BDP_RUNNING = 1'b1
    } bdp_ref_type;

endpackage : bdp_pkg

// ==== bdp_fifo.sv ====
// flip-flop fifo with valid/ready on both sides.
// assumes a single clock; depth must be a power of two.
module bdp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // filling side
    input wire logic i_s_valid,
    input wire logic [WIDTH-1:0] i_s_data,
    output logic o_s_ready,
    // draining side
    output logic o_m_valid,
    output logic [WIDTH-1:0] o_m_data,
    input wire logic i_m_ready,
    // fill level
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);

    // pointer arithmetic below wraps, so only powers of two work
    if ((DEPTH < 2) || ((1 << AW) != DEPTH)) begin : g_bad_depth
        $error("bdp_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];      // storage
    logic [AW:0] wr_reg, wr_next;           // write pointer with wrap bit
    logic [AW:0] rd_reg, rd_next;           // read pointer with wrap bit
    logic push, pop;

    // honest full and empty from the pointer difference
    assign o_level = wr_reg - rd_reg;
    assign o_s_ready = (o_level != DEPTH[AW:0] + {AW{1'b0}}) && !(o_level[AW]);
    assign o_m_valid = (wr_reg != rd_reg);
    assign o_m_data = mem_reg[rd_reg[AW-1:0]];

    // next pointers
    always_comb begin
        push = i_s_valid && o_s_ready;
        pop = o_m_valid && i_m_ready;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    end

    // pointers only; storage is written below
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // storage has no reset; nothing reads an unwritten slot
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= i_s_data;
        end
    end

endmodule : bdp_fifo

// ==== bdp_decim.sv ====
// third-order cascaded integrator-comb decimator for one channel.
// assumes one modulator symbol per i_sym_en pulse, two's complement.
`include "bdp_params.svh"
module bdp_decim #(
    parameter int IN_W = 3,
    parameter int OUT_W = 16,
    parameter int RATIO = `BDP_DEC_RATIO
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // modulator stream
    input wire logic i_sym_en,
    input wire logic [IN_W-1:0] i_sym,
    // decimated output
    output bdp_pkg::bdp_smp_type o_smp
);
    localparam int RW = $clog2(RATIO);
    localparam int W = IN_W + 3 * RW;        // growth of a third-order filter
    localparam int SH = W - OUT_W;           // full scale lands on 0x8000

    if (((1 << RW) != RATIO) || (SH < 0) || (OUT_W != 16)) begin : g_bad_cfg
        $error("bdp_decim needs a power-of-two ratio and a 16-bit output");
    end

    logic signed [W-1:0] i1_reg, i2_reg, i3_reg, i1_next, i2_next, i3_next;
    logic signed [W-1:0] z1_reg, z2_reg, z3_reg, z1_next, z2_next, z3_next;
    logic [RW-1:0] cnt_reg, cnt_next;        // symbols into this window
    bdp_pkg::bdp_smp_type smp_next;
    logic signed [W-1:0] y1, y2, y3, sym_ext;

    // integrators at the symbol rate, combs at the output rate;
    // wraparound in the integrators is harmless in modular arithmetic
    always_comb begin
        sym_ext = W'(signed'(i_sym));
        {i1_next, i2_next, i3_next} = {i1_reg, i2_reg, i3_reg};
        {z1_next, z2_next, z3_next} = {z1_reg, z2_reg, z3_reg};
        cnt_next = cnt_reg;
        smp_next = '{vld: 1'b0, data: o_smp.data};
        y1 = i3_reg - z1_reg;
        y2 = y1 - z2_reg;
        y3 = y2 - z3_reg;
        if (i_sym_en) begin
            i1_next = i1_reg + sym_ext;
            i2_next = i2_reg + i1_reg;
            i3_next = i3_reg + i2_reg;
            cnt_next = cnt_reg + 1'b1;
            // one output per RATIO symbols
            if (cnt_reg == RW'(RATIO - 1)) begin
                {z1_next, z2_next, z3_next} = {i3_reg, y1, y2};
                smp_next.vld = 1'b1;
                smp_next.data = OUT_W'(y3 >>> SH);
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            {i1_reg, i2_reg, i3_reg, z1_reg, z2_reg, z3_reg} <= '0;
            cnt_reg <= '0;
            o_smp <= '0;
        end else begin
            {i1_reg, i2_reg, i3_reg} <= {i1_next, i2_next, i3_next};
            {z1_reg, z2_reg, z3_reg} <= {z1_next, z2_next, z3_next};
            cnt_reg <= cnt_next;
            o_smp <= smp_next;
        end
    end

    // helper: symbols seen since the last output
    logic [RW:0] seen_reg;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            seen_reg <= '0;
        end else if (o_smp.vld) begin
            seen_reg <= (RW + 1)'(i_sym_en);
        end else if (i_sym_en) begin
            seen_reg <= seen_reg + 1'b1;
        end
    end

    out_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (o_smp.vld && $past(o_smp.vld != 1'b1)) |-> seen_reg == RATIO[RW:0])
        else $error("decimator output not aligned to its window");

endmodule : bdp_decim

// ==== bdp_mod_model.sv ====
// behavioural sigma-delta modulator standing in front of one decimator.
// assumes the block's o_mod_en pulse marks each 1 MHz symbol slot.
module bdp_mod_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // symbol slot and wanted average level
    input wire logic i_mod_en,
    input wire logic [2:0] i_level,
    // symbol stream towards the block
    output logic [2:0] o_sym
);
    timeunit 1ns;
    timeprecision 1ps;
    // one new 3-bit symbol per slot, changed just after the taking edge
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sym <= 3'h0;
        end else if (i_mod_en) begin
            o_sym <= i_level;
        end
    end
endmodule : bdp_mod_model

// ==== bdp_top_test.sv ====
// self-checking bench for the decimation path: register port, channels, fifo.
// assumes bdp_pkg and the design files are compiled first.
module bdp_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 4; // small fifo so overflow comes quickly
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic [2:0] p_sym, t_sym, p_lvl = 3'h4, t_lvl = 3'h6; // averages -4 and -2
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic i_wr = 1'b0, i_rd = 1'b0, o_ref_settled, o_mod_en;
    bdp_pkg::bdp_cfg_type o_cfg;
    int error_cnt = 0, total_checks = 0;
    // clock at 40 MHz
    initial begin
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    bdp_top #(.FIFO_DEPTH(DEPTH), .SETTLE_CYC(20)) dut (.i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn), .i_p_sym(p_sym), .i_t_sym(t_sym), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cfg(o_cfg),
        .o_ref_settled(o_ref_settled), .o_mod_en(o_mod_en));
    bdp_mod_model p_mod (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_mod_en(o_mod_en),
        .i_level(p_lvl), .o_sym(p_sym));
    bdp_mod_model t_mod (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_mod_en(o_mod_en),
        .i_level(t_lvl), .o_sym(t_sym));
    // one compare, counted; unknowns never match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    // poll status until a pressure sample is held, bounded
    task automatic wait_held(output int cyc);
        logic [7:0] s;
        cyc = 0;
        do begin
            rd(8'h08, s);
            cyc += 2;
        end while (s[0] !== 1'b1 && cyc < 12000);
        if (cyc >= 12000) begin
            chk(16'h0, 16'h1, "sample wait ran out");
            stop_test();
        end
    endtask : wait_held
    task automatic t_reset;
        int n;
        chk(o_cfg, 16'h0, "cfg reset");
        chk(o_ref_settled, 1'b0, "settled in reset");
        @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (15) @(posedge i_clk_sys);
        #1 chk(o_ref_settled, 1'b0, "settled too early");
        n = 0;
        // sampled mid-cycle, where the registered pulse has settled
        repeat (400) @(negedge i_clk_sys) n += (o_mod_en === 1'b1);
        chk(16'(n), 16'h000a, "symbol slots per 400 cycles");
        chk(o_ref_settled, 1'b1, "not settled");
        $display("test reset done");
    endtask : t_reset
    task automatic t_cfg;
        logic [7:0] d;
        wr(8'h04, 8'h1f);
        wr(8'h05, 8'h03);
        wr(8'h06, 8'h02);
        wr(8'h07, 8'h17);
        chk(o_cfg, {5'h1f, 2'h3, 2'h2, 3'h7, 1'b1}, "cfg fields");
        wr(8'h30, 8'hff);
        rd(8'h30, d);
        chk(d, 8'h00, "unmapped read");
        chk(o_cfg, {5'h1f, 2'h3, 2'h2, 3'h7, 1'b1}, "unmapped write");
        $display("test config done");
    endtask : t_cfg
    task automatic t_conv;
        logic [7:0] s, l, hi, lo;
        int c;
        realtime t1;
        for (int i = 0; i < 40; i++) begin
            rd(8'h08, s);
            rd(8'h09, l);
            if (s[0] === 1'b0 && l === 8'h00) break;
            rd(8'h01, lo);
        end
        chk({l, s[0]}, 9'h000, "start drain");
        // the first two outputs carry the filter's start-up transient
        wait_held(c);
        rd(8'h01, lo);
        wait_held(c);
        t1 = $realtime;
        rd(8'h01, lo);
        wait_held(c);
        c = int'(($realtime - t1) / 25.0);
        chk(c >= 5116 && c <= 5124, 1'b1, "sample spacing");
        rd(8'h00, hi);
        rd(8'h01, lo);
        chk({hi, lo}, 16'h8000, "pressure full scale");
        rd(8'h02, hi);
        rd(8'h03, lo);
        chk({hi, lo}, 16'hc000, "temperature half scale");
        $display("test conversion done");
    endtask : t_conv
    task automatic t_ovf;
        logic [7:0] s, l, d;
        repeat (6 * 5120) @(posedge i_clk_sys);
        rd(8'h09, l);
        chk(l, 16'(DEPTH), "fifo full level");
        rd(8'h08, s);
        chk(s[1], 1'b1, "overflow flag");
        wr(8'h08, 8'h02);
        rd(8'h08, s);
        chk(s[1], 1'b0, "overflow clear");
        repeat (DEPTH + 1) rd(8'h01, d);
        rd(8'h09, l);
        rd(8'h08, s);
        chk({l, s[0]}, 9'h0, "fifo drained");
        $display("test overflow done");
    endtask : t_ovf
    // main sequence: reset held 20 cycles
    initial begin
        repeat (20) @(posedge i_clk_sys);
        t_reset();
        t_cfg();
        t_conv();
        t_ovf();
        stop_test();
    end
endmodule : bdp_top_test
